/* lcu_consts.svh */
// offsets, field positions, opcodes and reset values of the command decoder
// assumes inclusion by bare name from the decoder and its bench
`ifndef LCU_CONSTS_SVH
`define LCU_CONSTS_SVH

// ************************************************************
// register byte offsets on the apb bus
// ************************************************************
`define LCU_OFS_STATUS 8'h00
`define LCU_OFS_CMD 8'h04
`define LCU_OFS_GPTR 8'h08
`define LCU_OFS_BASE 8'h0c
`define LCU_OFS_DUMP_ADDR 8'h10

// ************************************************************
// field positions inside the command and status words
// ************************************************************
`define LCU_CMD_HI 7
`define LCU_CMD_LO 4
`define LCU_RX_HI 2
`define LCU_RX_LO 0
`define LCU_BUSY_BIT 16

// ************************************************************
// command engine opcodes
// ************************************************************
`define LCU_CMD_NO_OPERATION 4'h0
`define LCU_CMD_START 4'h1
`define LCU_CMD_RESUME 4'h2
`define LCU_CMD_PRIO_START 4'h3
`define LCU_CMD_LOAD_DUMP 4'h4
`define LCU_CMD_DUMP 4'h5
`define LCU_CMD_LOAD_BASE 4'h6
`define LCU_CMD_DUMP_CLEAR 4'h7
`define LCU_CMD_STATIC_RESUME 4'ha
`define LCU_CMD_PRIO_RESUME 4'hb

// ************************************************************
// receive engine opcodes and status codes
// ************************************************************
`define LCU_RX_NO_OPERATION 3'h0
`define LCU_RX_ABORT 3'h4
`define LCU_RXS_IDLE 4'h0
`define LCU_RXS_READY 4'h4

// ************************************************************
// sizes and reset values
// ************************************************************
`define LCU_NUM_CNT 4
`define LCU_WORD_BYTES 32'h0000_0004
`define LCU_RST_WORD 32'h0000_0000

`endif

/* lcu_pkg.sv */
// types shared by the command decoder files
// assumes nothing beyond a systemverilog compiler
package lcu_pkg;

  // engine state, order gives the two-bit status code
  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_SUSP,
    ENG_LOW_ACTIVE,
    ENG_PRIO_ACTIVE
  } lcu_eng_e;

  // statistics dump sequencer
  typedef enum logic {
    DUMP_IDLE,
    DUMP_WRITE
  } lcu_dump_e;

  // one word written to main memory
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } lcu_mem_wr_s;

endpackage : lcu_pkg

/* lcu_apb_slave.sv */
// apb slave front end: registered pready, prdata and pslverr
// assumes the core decodes paddr combinationally into rd_word and addr_ok
`timescale 1ns/100ps
module lcu_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] rd_word,
  input wire logic addr_ok,
  input wire logic stall,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic wr_pulse
);

  // ************************************************************
  // access phase handling
  // ************************************************************
  // pready rises one cycle into the access phase; wr_pulse stands in
  // the same cycle so the core commits at the edge that samples pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      wr_pulse <= 1'b0;
    end
    else if (ce)
    begin
      if (psel && penable && !pready && !stall)
      begin
        pready <= 1'b1;
        prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_word;
        pslverr <= !addr_ok; // unmapped address
        wr_pulse <= pwrite && addr_ok;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        wr_pulse <= 1'b0;
      end
    end
  end

endmodule : lcu_apb_slave

/* lcu_stat_counter.sv */
// one 32-bit statistics counter with synchronous clear
// assumes inc and clr are single-cycle pulses in the pclk domain
`timescale 1ns/100ps
module lcu_stat_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic inc,
  input wire logic clr,
  output logic [31:0] count
);

  // an event in the clear cycle is kept as a count of one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 32'h0000_0000;
    else if (ce)
    begin
      if (clr)
        count <= {31'h0000_0000, inc};
      else
        count <= count + {31'h0000_0000, inc};
    end
  end

endmodule : lcu_stat_counter

/* lcu_decoder.sv */
// command word decoder for the lan command and receive engines
// assumes an apb master on pclk and engines that pulse their events
//
// Operation
// RULE1: opcode for the command engine sits in command word bits 7:4; others reserved.
// RULE2: opcode 0000 leaves the command engine state as it is.
// RULE3: opcode 0001 starts the normal list at the general pointer address; the code fetches the first block from base_reg + gptr.
// RULE4: software starts a list only when idle or suspended and all blocks done.
// RULE5: opcode 0010 resumes with the next block; ignored while idle.
// RULE6: opcode 0011 starts the high-priority list at the general pointer address; the code fetches the first block from base_reg + gptr.
// RULE7: opcode 0100 latches the general pointer as the dump address.
// RULE8: software loads the dump address before any dump command.
// RULE9: opcode 0101 writes counters to the dump address, counters kept.
// RULE10: opcode 0111 writes counters to the dump address, then clears them.
// RULE11: opcode 0110 loads the base register from the general pointer.
// RULE12: opcode 1010 resumes like 0010; software uses it only when suspended.
// RULE13: opcode 1011 resumes the high-priority list; ignored if never started.
// RULE14: receive opcode 000 leaves the receive engine state as it is.
// RULE15: receive opcode sits in bits 2:0; 100 aborts reception at once.
// RULE16: command engine state reads in status bits 7:6 as four codes.
// RULE17: software loads the general pointer with the structure the command needs.
// RULE18: each command word write acts once; reserved opcodes change nothing.
`timescale 1ns/100ps
`include "lcu_consts.svh"
module lcu_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic blk_suspend,
  input wire logic list_end,
  input wire logic rx_up_evt,
  input wire logic [3:0] stat_evt,
  output logic eng_fetch,
  output logic eng_resume,
  output logic eng_prio,
  output logic [31:0] eng_fetch_addr,
  output logic rx_abort,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output lcu_pkg::lcu_mem_wr_s mem_wr
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [31:0] gptr;
  logic [31:0] base_reg;
  logic [31:0] dump_addr;
  lcu_pkg::lcu_eng_e eng_state;
  lcu_pkg::lcu_eng_e next_eng_state;
  logic prio_started;
  logic low_held;
  logic next_low_held;
  logic rx_up;
  lcu_pkg::lcu_dump_e dump_state;
  logic [1:0] dump_idx;
  logic [1:0] next_idx;
  logic dump_clr;
  logic cnt_clr;
  logic [31:0] cnt_val [`LCU_NUM_CNT];
  logic wr_pulse;
  logic addr_ok;
  logic stall;
  logic [31:0] rd_word;
  logic cmd_wr;
  logic [3:0] cmd_unit_opcode;
  logic [2:0] rx_unit_opcode;
  logic dump_busy;

  // ************************************************************
  // bus front end and command decode
  // ************************************************************
  lcu_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .rd_word(rd_word),
    .addr_ok(addr_ok),
    .stall(stall),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .wr_pulse(wr_pulse)
  );

  // RULE18 once per write
  // wr_pulse lasts one cycle, so each command word write decodes once
  assign cmd_wr = wr_pulse && (paddr == `LCU_OFS_CMD);
  // RULE1 command opcode field
  assign cmd_unit_opcode = pwdata[`LCU_CMD_HI:`LCU_CMD_LO];
  // RULE15 receive opcode field
  assign rx_unit_opcode = pwdata[`LCU_RX_HI:`LCU_RX_LO];
  assign dump_busy = (dump_state != lcu_pkg::DUMP_IDLE);
  // command writes wait while a dump runs, so no command is dropped
  assign stall = dump_busy && psel && pwrite && (paddr == `LCU_OFS_CMD);

  // read mux; the command word always reads as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      // RULE16 engine state field
      `LCU_OFS_STATUS: rd_word = {15'h0000, dump_busy, 8'h00, eng_state,
                                 (rx_up ? `LCU_RXS_READY : `LCU_RXS_IDLE), 2'h0};
      `LCU_OFS_CMD: rd_word = 32'h0000_0000;
      `LCU_OFS_GPTR: rd_word = gptr;
      `LCU_OFS_BASE: rd_word = base_reg;
      `LCU_OFS_DUMP_ADDR: rd_word = dump_addr;
      default: addr_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // pointer registers
  // ************************************************************
  // general pointer written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gptr <= `LCU_RST_WORD;
    else if (ce && wr_pulse && (paddr == `LCU_OFS_GPTR))
      gptr <= pwdata;
  end

  // base and dump address loads from the general pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base_reg <= `LCU_RST_WORD;
      dump_addr <= `LCU_RST_WORD;
    end
    else if (ce && cmd_wr)
    begin
      // RULE11 base load
      if (cmd_unit_opcode == `LCU_CMD_LOAD_BASE)
        base_reg <= gptr;
      // RULE7 dump address latch
      if (cmd_unit_opcode == `LCU_CMD_LOAD_DUMP)
        dump_addr <= gptr;
    end
  end

  // ************************************************************
  // command engine state
  // ************************************************************
  // engine events first, then the command on top, so the command wins where both set the state
  always_comb
  begin
    next_eng_state = eng_state;
    next_low_held = low_held;
    if (list_end)
    begin
      if (eng_state == lcu_pkg::ENG_PRIO_ACTIVE)
      begin
        next_eng_state = low_held ? lcu_pkg::ENG_LOW_ACTIVE : lcu_pkg::ENG_IDLE;
        next_low_held = 1'b0;
      end
      else if (eng_state == lcu_pkg::ENG_LOW_ACTIVE)
        next_eng_state = lcu_pkg::ENG_IDLE;
    end
    else if (blk_suspend && eng_state != lcu_pkg::ENG_IDLE)
      next_eng_state = lcu_pkg::ENG_SUSP;
    if (cmd_wr)
    begin
      case (cmd_unit_opcode)
        // RULE3 normal list start
        `LCU_CMD_START: next_eng_state = lcu_pkg::ENG_LOW_ACTIVE;
        // RULE5 resume ignored when idle
        `LCU_CMD_RESUME,
        // RULE12 static resume
        `LCU_CMD_STATIC_RESUME:
          if (eng_state == lcu_pkg::ENG_SUSP)
            next_eng_state = lcu_pkg::ENG_LOW_ACTIVE;
        // RULE6 priority list start
        `LCU_CMD_PRIO_START:
        begin
          next_low_held = (eng_state == lcu_pkg::ENG_LOW_ACTIVE) || low_held;
          next_eng_state = lcu_pkg::ENG_PRIO_ACTIVE;
        end
        // RULE13 priority resume only after a start
        `LCU_CMD_PRIO_RESUME:
          if (prio_started)
          begin
            next_low_held = (eng_state == lcu_pkg::ENG_LOW_ACTIVE) || low_held;
            next_eng_state = lcu_pkg::ENG_PRIO_ACTIVE;
          end
        // RULE2 no operation keeps state
        // RULE18 reserved opcodes ignored
        default: ;
      endcase
    end
  end

  // state registers of the engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eng_state <= lcu_pkg::ENG_IDLE;
      low_held <= 1'b0;
      prio_started <= 1'b0;
    end
    else if (ce)
    begin
      eng_state <= next_eng_state;
      low_held <= next_low_held;
      if (cmd_wr && cmd_unit_opcode == `LCU_CMD_PRIO_START)
        prio_started <= 1'b1;
    end
  end

  // fetch and resume pulses to the engine, one per taken command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eng_fetch <= 1'b0;
      eng_resume <= 1'b0;
      eng_prio <= 1'b0;
      eng_fetch_addr <= `LCU_RST_WORD;
    end
    else if (ce)
    begin
      eng_fetch <= 1'b0;
      eng_resume <= 1'b0;
      if (cmd_wr)
      begin
        case (cmd_unit_opcode)
          // RULE3 first block address
          `LCU_CMD_START:
          begin
            eng_fetch <= 1'b1;
            eng_prio <= 1'b0;
            eng_fetch_addr <= base_reg + gptr;
          end
          // RULE6 priority first block address
          `LCU_CMD_PRIO_START:
          begin
            eng_fetch <= 1'b1;
            eng_prio <= 1'b1;
            eng_fetch_addr <= base_reg + gptr;
          end
          // RULE5 next block unless idle
          `LCU_CMD_RESUME,
          `LCU_CMD_STATIC_RESUME:
            if (eng_state != lcu_pkg::ENG_IDLE)
            begin
              eng_resume <= 1'b1;
              eng_prio <= (eng_state == lcu_pkg::ENG_PRIO_ACTIVE);
            end
          // RULE13 priority resume gated
          `LCU_CMD_PRIO_RESUME:
            if (prio_started)
            begin
              eng_resume <= 1'b1;
              eng_prio <= 1'b1;
            end
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // receive engine control
  // ************************************************************
  // abort outranks a same-cycle bring-up: reception must stop at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_up <= 1'b0;
      rx_abort <= 1'b0;
    end
    else if (ce)
    begin
      rx_abort <= 1'b0;
      // RULE15 immediate abort
      if (cmd_wr && rx_unit_opcode == `LCU_RX_ABORT)
      begin
        rx_up <= 1'b0;
        rx_abort <= 1'b1;
      end
      // RULE14 no operation keeps state
      else if (rx_up_evt)
        rx_up <= 1'b1;
    end
  end

  // ************************************************************
  // statistics counters and dump
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `LCU_NUM_CNT; gi++)
    begin : g_cnt
      lcu_stat_counter u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .inc(stat_evt[gi]),
        .clr(cnt_clr),
        .count(cnt_val[gi])
      );
    end
  endgenerate

  assign next_idx = dump_idx + 2'h1;

  // dump walks the counters one word each; counts are taken live, so an
  // event during the walk may show in a later word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dump_state <= lcu_pkg::DUMP_IDLE;
      dump_idx <= 2'h0;
      dump_clr <= 1'b0;
      cnt_clr <= 1'b0;
      mem_wr_valid <= 1'b0;
      mem_wr <= '0;
    end
    else if (ce)
    begin
      cnt_clr <= 1'b0;
      case (dump_state)
        lcu_pkg::DUMP_IDLE:
          // RULE9 dump keeps counters
          if (cmd_wr && (cmd_unit_opcode == `LCU_CMD_DUMP ||
                         cmd_unit_opcode == `LCU_CMD_DUMP_CLEAR))
          begin
            dump_state <= lcu_pkg::DUMP_WRITE;
            dump_idx <= 2'h0;
            dump_clr <= (cmd_unit_opcode == `LCU_CMD_DUMP_CLEAR);
            mem_wr_valid <= 1'b1;
            mem_wr.addr <= dump_addr;
            mem_wr.data <= cnt_val[0];
          end
        lcu_pkg::DUMP_WRITE:
          if (mem_wr_ready)
          begin
            if (dump_idx == 2'(`LCU_NUM_CNT - 1))
            begin
              dump_state <= lcu_pkg::DUMP_IDLE;
              mem_wr_valid <= 1'b0;
              // RULE10 clear after the last word
              cnt_clr <= dump_clr;
            end
            else
            begin
              dump_idx <= next_idx;
              mem_wr.addr <= mem_wr.addr + `LCU_WORD_BYTES;
              mem_wr.data <= cnt_val[next_idx];
            end
          end
        default: dump_state <= lcu_pkg::DUMP_IDLE;
      endcase
    end
  end

  // ************************************************************
  // assertions and covers
  // ************************************************************
  default clocking cb_main @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  start_low_list_a: assert property ( // RULE3
    ce && cmd_wr && cmd_unit_opcode == `LCU_CMD_START |=>
    eng_state == lcu_pkg::ENG_LOW_ACTIVE && eng_fetch && !eng_prio &&
    eng_fetch_addr == $past(base_reg) + $past(gptr))
    else $error("normal list start not taken");

  resume_idle_a: assert property ( // RULE5
    ce && cmd_wr && eng_state == lcu_pkg::ENG_IDLE &&
    (cmd_unit_opcode == `LCU_CMD_RESUME ||
     cmd_unit_opcode == `LCU_CMD_STATIC_RESUME) |=> !eng_resume)
    else $error("resume acted while idle");

  no_op_keep_a: assert property ( // RULE2
    ce && cmd_wr && cmd_unit_opcode == `LCU_CMD_NO_OPERATION &&
    !list_end && !blk_suspend |=> $stable(eng_state) && !eng_fetch)
    else $error("no operation changed engine state");

  prio_start_a: assert property ( // RULE6
    ce && cmd_wr && cmd_unit_opcode == `LCU_CMD_PRIO_START |=>
    eng_state == lcu_pkg::ENG_PRIO_ACTIVE && eng_fetch && eng_prio && prio_started)
    else $error("priority start not taken");

  prio_never_a: assert property ( // RULE13
    ce && cmd_wr && cmd_unit_opcode == `LCU_CMD_PRIO_RESUME && !prio_started
    |=> !eng_resume && eng_state != lcu_pkg::ENG_PRIO_ACTIVE)
    else $error("priority resume before any start");

  dump_addr_a: assert property ( // RULE7
    ce && cmd_wr && cmd_unit_opcode == `LCU_CMD_LOAD_DUMP |=>
    dump_addr == $past(gptr))
    else $error("dump address not latched");

  base_load_a: assert property ( // RULE11
    ce && cmd_wr && cmd_unit_opcode == `LCU_CMD_LOAD_BASE |=>
    base_reg == $past(gptr))
    else $error("base register not loaded");

  dump_keep_a: assert property ( // RULE9
    ce && cmd_wr && !dump_busy && cmd_unit_opcode == `LCU_CMD_DUMP |=>
    mem_wr_valid && mem_wr.addr == $past(dump_addr) && !dump_clr)
    else $error("plain dump started wrongly");

  clear_cause_a: assert property ( // RULE10
    cnt_clr |-> dump_clr && $past(mem_wr_valid) && !mem_wr_valid)
    else $error("counters cleared without dump and clear");

  rx_abort_a: assert property ( // RULE15
    ce && cmd_wr && rx_unit_opcode == `LCU_RX_ABORT |=> rx_abort && !rx_up)
    else $error("receive abort not immediate");

  fetch_pulse_a: assert property ( // RULE18
    ce && eng_fetch |=> !eng_fetch)
    else $error("fetch pulse held longer than one cycle");

  start_cov: cover property (
    cmd_wr && cmd_unit_opcode == `LCU_CMD_START ##[1:50] list_end);
  dump_clear_cov: cover property (
    cmd_wr && cmd_unit_opcode == `LCU_CMD_DUMP_CLEAR ##[4:100] cnt_clr);
  prio_resume_cov: cover property (
    prio_started && cmd_wr && cmd_unit_opcode == `LCU_CMD_PRIO_RESUME ##1 eng_resume);
  rx_abort_cov: cover property (rx_up ##1 rx_abort);

endmodule : lcu_decoder

/* lcu_mem_model.sv */
// main memory model behind the statistics dump port
// assumes pclk domain; a word is taken at an edge with valid and ready high
`timescale 1ns/100ps
module lcu_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic mem_wr_valid,
  input wire lcu_pkg::lcu_mem_wr_s mem_wr,
  output logic mem_wr_ready,
  output logic [15:0][31:0] words
);
  // slow mode toggles ready, so the dump walk must hold each word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_wr_ready <= 1'b0;
    else
      mem_wr_ready <= slow ? ~mem_wr_ready : 1'b1;
  end

  // words land at index addr[5:2]; unwritten words keep all ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      words <= {16{32'hffff_ffff}};
    else if (mem_wr_valid && mem_wr_ready)
      words[mem_wr.addr[5:2]] <= mem_wr.data;
  end
endmodule : lcu_mem_model

/* lcu_decoder_tb.sv */
// self-checking bench for the command word decoder
// assumes the memory model on the dump port; apb accesses wait on pready
`timescale 1ns/100ps
`include "lcu_consts.svh"
module lcu_decoder_tb;
  // ************
  // signals
  // ************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic blk_suspend = 1'b0;
  logic list_end = 1'b0;
  logic rx_up_evt = 1'b0;
  logic [3:0] stat_evt = 4'h0;
  logic eng_fetch;
  logic eng_resume;
  logic eng_prio;
  logic rx_abort;
  logic mem_wr_valid;
  logic mem_wr_ready;
  logic [31:0] eng_fetch_addr;
  lcu_pkg::lcu_mem_wr_s mem_wr;
  logic [15:0][31:0] words;
  logic slow = 1'b1;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  lcu_decoder lcu_decoder_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .blk_suspend(blk_suspend), .list_end(list_end),
    .rx_up_evt(rx_up_evt), .stat_evt(stat_evt), .eng_fetch(eng_fetch),
    .eng_resume(eng_resume), .eng_prio(eng_prio), .eng_fetch_addr(eng_fetch_addr),
    .rx_abort(rx_abort), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr(mem_wr));
  lcu_mem_model lcu_mem_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready),
    .words(words));

  // ************
  // tasks
  // ************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // request held up to the rising edge that samples pready high; data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [3:0] op, input logic [2:0] rx);
    apb(1'b1, `LCU_OFS_CMD, {24'h0, op, 1'b0, rx});
  endtask : cmd

  // exp is {fetch, resume, prio with a pulse, rx abort}; pulses last one cycle
  task automatic eng(input logic [3:0] exp, input logic [31:0] a, input string what);
    @(negedge pclk);
    chk({28'h0, eng_fetch, eng_resume, eng_prio & (eng_fetch | eng_resume), rx_abort},
      {28'h0, exp}, what);
    if (exp[3])
      chk(eng_fetch_addr, a, what);
    @(negedge pclk);
    chk({29'h0, eng_fetch, eng_resume, rx_abort}, 32'h0, what);
  endtask : eng

  task automatic status(input logic [1:0] st, input logic [3:0] rxs, input string what);
    apb(1'b0, `LCU_OFS_STATUS, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, st, rxs, 2'b00}, what);
  endtask : status

  // drives {blk_suspend, list_end, rx_up_evt, stat_evt} for one cycle
  task automatic pulse(input logic [6:0] v);
    @(posedge pclk);
    {blk_suspend, list_end, rx_up_evt, stat_evt} <= v;
    @(posedge pclk);
    {blk_suspend, list_end, rx_up_evt, stat_evt} <= 7'h00;
  endtask : pulse

  task automatic dump(input logic [31:0] a, input logic [3:0] op);
    apb(1'b1, `LCU_OFS_GPTR, a);
    cmd(`LCU_CMD_LOAD_DUMP, `LCU_RX_NO_OPERATION);
    apb(1'b0, `LCU_OFS_DUMP_ADDR, 32'h0);
    chk(rd, a, "dump address");
    cmd(op, `LCU_RX_NO_OPERATION);
    apb(1'b0, `LCU_OFS_STATUS, 32'h0);
    if (slow)
      chk({31'h0, rd[`LCU_BUSY_BIT]}, 32'h1, "dump busy");
    while (rd[`LCU_BUSY_BIT] !== 1'b0)
      apb(1'b0, `LCU_OFS_STATUS, 32'h0);
  endtask : dump

  // counter i was bumped 4 - i times before any clear
  task automatic dump_words(input int at, input logic [31:0] scale);
    for (int i = 0; i < `LCU_NUM_CNT; i++)
      chk(words[at + i], scale * (4 - i), "dump word");
  endtask : dump_words

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // ************
  // tests
  // ************
  task automatic t_regs;
    status(2'b00, `LCU_RXS_IDLE, "idle after reset");
    apb(1'b0, `LCU_OFS_GPTR, 32'h0);
    chk(rd, `LCU_RST_WORD, "gptr reset");
    apb(1'b1, `LCU_OFS_BASE, 32'h1234_5678);
    apb(1'b0, `LCU_OFS_BASE, 32'h0);
    chk(rd, `LCU_RST_WORD, "base read only");
    apb(1'b1, 8'h14, 32'h5);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b0, `LCU_OFS_CMD, 32'h0);
    chk(rd, 32'h0, "cmd reads zero");
    $display("test regs done");
  endtask : t_regs

  task automatic t_idle;
    logic [3:0] ops [10] = '{4'h0, 4'h2, 4'ha, 4'hb, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
    apb(1'b1, `LCU_OFS_GPTR, 32'h0000_0100);
    foreach (ops[i])
    begin
      cmd(ops[i], `LCU_RX_NO_OPERATION);
      eng(4'h0, 32'h0, "idle op ignored");
      status(2'b00, `LCU_RXS_IDLE, "still idle");
    end
    cmd(`LCU_CMD_LOAD_BASE, `LCU_RX_NO_OPERATION);
    apb(1'b0, `LCU_OFS_BASE, 32'h0);
    chk(rd, 32'h0000_0100, "base loaded");
    $display("test idle done");
  endtask : t_idle

  task automatic t_rx;
    pulse(7'h10);
    cmd(`LCU_CMD_NO_OPERATION, `LCU_RX_NO_OPERATION);
    eng(4'h0, 32'h0, "rx no-op");
    status(2'b00, `LCU_RXS_READY, "rx stays ready");
    cmd(`LCU_CMD_NO_OPERATION, `LCU_RX_ABORT);
    eng(4'h1, 32'h0, "rx abort pulse");
    status(2'b00, `LCU_RXS_IDLE, "rx aborted");
    $display("test rx done");
  endtask : t_rx

  // start issued from idle with pointer set
  task automatic t_lists;
    apb(1'b1, `LCU_OFS_GPTR, 32'h0000_0020);
    cmd(`LCU_CMD_START, `LCU_RX_NO_OPERATION);
    eng(4'h8, 32'h0000_0120, "normal start");
    status(2'b10, `LCU_RXS_IDLE, "low list active");
    pulse(7'h40);
    status(2'b01, `LCU_RXS_IDLE, "suspended");
    cmd(`LCU_CMD_RESUME, `LCU_RX_NO_OPERATION);
    eng(4'h4, 32'h0, "resume");
    status(2'b10, `LCU_RXS_IDLE, "resumed");
    pulse(7'h40);
    cmd(`LCU_CMD_STATIC_RESUME, `LCU_RX_NO_OPERATION);
    eng(4'h4, 32'h0, "static resume");
    status(2'b10, `LCU_RXS_IDLE, "static resumed");
    apb(1'b1, `LCU_OFS_GPTR, 32'h0000_0040);
    cmd(`LCU_CMD_PRIO_START, `LCU_RX_NO_OPERATION);
    eng(4'ha, 32'h0000_0140, "prio start");
    status(2'b11, `LCU_RXS_IDLE, "prio active");
    pulse(7'h20);
    status(2'b10, `LCU_RXS_IDLE, "back to low list");
    pulse(7'h20);
    status(2'b00, `LCU_RXS_IDLE, "list done");
    cmd(`LCU_CMD_PRIO_RESUME, `LCU_RX_NO_OPERATION);
    eng(4'h6, 32'h0, "prio resume after start");
    $display("test lists done");
  endtask : t_lists

  task automatic t_dump;
    pulse(7'h0f);
    pulse(7'h07);
    pulse(7'h03);
    pulse(7'h01);
    dump(32'h0000_0200, `LCU_CMD_DUMP);
    dump_words(0, 32'h1);
    slow <= 1'b0;
    dump(32'h0000_0210, `LCU_CMD_DUMP_CLEAR);
    dump_words(4, 32'h1);
    dump(32'h0000_0220, `LCU_CMD_DUMP);
    dump_words(8, 32'h0);
    $display("test dump done");
  endtask : t_dump

  // reset for four cycles, then the tests in turn
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_idle;
    t_rx;
    t_lists;
    t_dump;
    end_of_test;
  end

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test;
  end
endmodule : lcu_decoder_tb
